// file: src/memory_map_pkg.sv
// Constants and types shared by the memory map decoder
package memory_map_pkg;
   // Control and status register offsets, field bits and reset values
   localparam logic [3:0]  CTRL_OFFSET       = 4'h0;
   localparam logic [3:0]  STATUS_OFFSET     = 4'h1;
   localparam int          UPPER_EN_BIT      = 0;
   localparam int          PAGE_SEL_LSB      = 1;
   localparam int          WIDTH0_BIT        = 3;
   localparam int          WIDTH1_BIT        = 4;
   localparam logic        UPPER_EN_RESET    = 1'b0;
   localparam logic [1:0]  PAGE_SEL_RESET    = 2'h0;
   localparam logic        WIDTH_RESET       = 1'b1;

   // Program space layout, word addresses
   localparam logic [15:0] USER_CODE_FIRST   = 16'h0000;
   localparam logic [15:0] USER_CODE_LAST    = 16'h7fff;
   localparam logic [15:0] ROM_FETCH_BASE    = 16'h8000;
   localparam logic [15:0] SRAM_FETCH_BASE   = 16'ha000;

   // Data space layout
   localparam logic [15:0] DATA_UPPER_BASE   = 16'h8000;
   localparam logic [15:0] DATA_ROM_BASE     = 16'h8000;
   localparam logic [15:0] PAGE_BASE_ROMEXEC = 16'h8000;
   localparam logic [15:0] PAGE_BASE_RAMEXEC = 16'h0000;

   // Physical segment sizes
   localparam int          PAGE_AW           = 14;
   localparam int          ROM_AW            = 13;
   localparam int          SRAM_AW           = 14;

   typedef enum logic [1:0] {
      SEG_USER,
      SEG_ROM,
      SEG_SRAM
   } seg_t;

   localparam seg_t        EXEC_SEG_RESET    = SEG_ROM;

   // Result of one address decode
   typedef struct packed {
      seg_t        seg;
      logic [15:0] word_addr;
      logic        byte_mode;
      logic        lane;
   } route_t;

   // Read in flight, waiting for memory data
   typedef struct packed {
      logic        valid;
      seg_t        seg;
      logic        byte_mode;
      logic        lane;
   } pend_t;
endpackage : memory_map_pkg

// file: src/unified_memory_map_decoder.sv
// Pseudo-Von Neumann memory map decoder with byte-lane steering
//
// Summary of operation
// - Program words 0000h-7FFFh are user code, then utility ROM, then data memory.
// - Physical program memory is four consecutive 16k-word pages.
// - Pages two and three execute only with upper page enable set, in upper half.
// - With upper page enable set, ROM and data memory cannot be fetched.
// - Code page select picks one page in byte mode, a page pair in word mode.
// - Byte mode maps one page into data space; word mode maps two pages.
// - Executing from ROM, selected pages read as data from 8000h.
// - Executing from data memory, pages appear at 0000h and ROM at 8000h.
// - From lower pages with upper enable clear, data memory fetches at A000h.
// - From lower pages, data reads from 8000h return ROM contents.
// - ROM or data memory execution is possible only with upper enable clear.
// - The segment supplying fetches is never accessed as data at once.
// - From data memory, flow passes freely between lower pages and ROM.
// - Loads and stores below 8000h reach data memory unless data memory is the executing segment.
// - Each pointer width select resets to one, word mode.
// - Data memory is two byte banks, common word address; reads return words.
// - Byte reads address the word without pointer bit 0, which picks the byte.
// - Byte writes enable only the bank chosen by pointer bit 0.
// - Every fetch delivers the full 16-bit word.
// - All sixteen pointer bits decode for pages and byte-mode SRAM; ROM ignores bit 14 (and 13 in word mode), word-mode SRAM bit 14.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module unified_memory_map_decoder (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   // Control register port
   input  wire logic [3:0]  i_reg_addr,
   input  wire logic [15:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [15:0] o_reg_rdata,
   // Instruction fetch
   input  wire logic        i_fetch_req,
   input  wire logic [15:0] i_fetch_addr,
   output logic             o_fetch_valid,
   output logic      [15:0] o_fetch_word,
   // Data pointer access
   input  wire logic        i_data_rd,
   input  wire logic        i_data_wr,
   input  wire logic        i_data_ptr,
   input  wire logic [15:0] i_data_addr,
   input  wire logic [15:0] i_data_wdata,
   output logic             o_data_valid,
   output logic      [15:0] o_data_rdata,
   // Program memory port
   output logic             o_prog_rd,
   output logic      [15:0] o_prog_addr,
   input  wire logic [15:0] i_prog_rdata,
   // Utility ROM port
   output logic             o_rom_rd,
   output logic      [12:0] o_rom_addr,
   input  wire logic [15:0] i_rom_rdata,
   // Data SRAM port, two byte banks
   output logic             o_sram_rd,
   output logic      [13:0] o_sram_addr,
   output logic             o_sram_we_lo,
   output logic             o_sram_we_hi,
   output logic      [15:0] o_sram_wdata,
   input  wire logic [15:0] i_sram_rdata
);

   logic                       upper_page_exec_enable;
   logic [1:0]                 code_page_select;
   logic [1:0]                 pointer_width_select;
   memory_map_pkg::seg_t       exec_seg;
   memory_map_pkg::seg_t       cur_exec;
   memory_map_pkg::route_t     f_route;
   memory_map_pkg::route_t     d_route;
   memory_map_pkg::pend_t      f_pend;
   memory_map_pkg::pend_t      d_pend;
   logic                       data_req;
   logic                       wide;
   logic                       next_prog_rd;
   logic                       next_rom_rd;
   logic                       next_sram_rd;
   logic                       next_we_lo;
   logic                       next_we_hi;
   logic [15:0]                next_prog_addr;
   logic [15:0]                next_rom_addr;
   logic [15:0]                next_sram_addr;
   logic [15:0]                d_word;

   // Word seen by a pending read, chosen by its source segment
   function automatic logic [15:0] pick_word(input memory_map_pkg::seg_t seg,
                                             input logic [15:0] prog,
                                             input logic [15:0] rom,
                                             input logic [15:0] sram);
      logic [15:0] w;
      w = prog;
      case (seg)
         memory_map_pkg::SEG_ROM:  w = rom;
         memory_map_pkg::SEG_SRAM: w = sram;
         default:                  w = prog;
      endcase
      return w;
   endfunction : pick_word

   // Offset into a window, folded to a word address in byte mode
   function automatic memory_map_pkg::route_t window(input memory_map_pkg::seg_t seg,
                                                     input logic [15:0] addr,
                                                     input logic [15:0] base,
                                                     input logic        wd);
      memory_map_pkg::route_t r;
      logic [15:0]            off;
      off         = addr - base;
      r.seg       = seg;
      r.byte_mode = ~wd;
      r.lane      = off[0] & ~wd;
      r.word_addr = wd ? off : {1'b0, off[15:1]};
      return r;
   endfunction : window

   always_comb begin
      f_route = '0;
      if (i_fetch_addr <= memory_map_pkg::USER_CODE_LAST) begin
         f_route.seg       = memory_map_pkg::SEG_USER;
         f_route.word_addr = i_fetch_addr - memory_map_pkg::USER_CODE_FIRST;
      end else if (upper_page_exec_enable) begin
         f_route.seg       = memory_map_pkg::SEG_USER;
         f_route.word_addr = i_fetch_addr;
      end else if (i_fetch_addr >= memory_map_pkg::SRAM_FETCH_BASE) begin
         f_route.seg       = memory_map_pkg::SEG_SRAM;
         f_route.word_addr = i_fetch_addr - memory_map_pkg::SRAM_FETCH_BASE;
      end else begin
         f_route.seg       = memory_map_pkg::SEG_ROM;
         f_route.word_addr = i_fetch_addr - memory_map_pkg::ROM_FETCH_BASE;
      end
   end

   // A fetch in the same cycle moves the execution segment first, so data never
   // lands on the segment that is fetching.
   assign cur_exec = i_fetch_req ? f_route.seg : exec_seg;
   assign data_req = i_data_rd | i_data_wr;
   assign wide     = pointer_width_select[i_data_ptr];

   always_comb begin
      d_route = '0;
      if (i_data_addr >= memory_map_pkg::DATA_UPPER_BASE) begin
         if (cur_exec == memory_map_pkg::SEG_ROM) begin
            d_route = window(memory_map_pkg::SEG_USER, i_data_addr,
                             memory_map_pkg::PAGE_BASE_ROMEXEC, wide);
         end else begin
            d_route = window(memory_map_pkg::SEG_ROM, i_data_addr,
                             memory_map_pkg::DATA_ROM_BASE, wide);
         end
      end else if (cur_exec == memory_map_pkg::SEG_SRAM) begin
         d_route = window(memory_map_pkg::SEG_USER, i_data_addr,
                          memory_map_pkg::PAGE_BASE_RAMEXEC, wide);
      end else begin
         d_route = window(memory_map_pkg::SEG_SRAM, i_data_addr,
                          16'h0000, wide);
      end
      if (d_route.seg == memory_map_pkg::SEG_USER) begin
         if (wide) begin
            d_route.word_addr = {code_page_select[1], d_route.word_addr[14:0]};
         end else begin
            d_route.word_addr = {code_page_select, d_route.word_addr[13:0]};
         end
      end
   end

   // Fetch and data never target the same memory, so each port sees at most one
   always_comb begin
      next_prog_rd   = 1'b0;
      next_rom_rd    = 1'b0;
      next_sram_rd   = 1'b0;
      next_we_lo     = 1'b0;
      next_we_hi     = 1'b0;
      next_prog_addr = d_route.word_addr;
      next_rom_addr  = d_route.word_addr;
      next_sram_addr = d_route.word_addr;
      if (i_data_rd) begin
         case (d_route.seg)
            memory_map_pkg::SEG_ROM:  next_rom_rd  = 1'b1;
            memory_map_pkg::SEG_SRAM: next_sram_rd = 1'b1;
            default:                  next_prog_rd = 1'b1;
         endcase
      end
      // Only data SRAM is writable from the pointers
      if (i_data_wr && d_route.seg == memory_map_pkg::SEG_SRAM) begin
         next_we_lo = ~d_route.byte_mode | ~d_route.lane;
         next_we_hi = ~d_route.byte_mode | d_route.lane;
      end
      if (i_fetch_req) begin
         case (f_route.seg)
            memory_map_pkg::SEG_ROM: begin
               next_rom_rd   = 1'b1;
               next_rom_addr = f_route.word_addr;
            end
            memory_map_pkg::SEG_SRAM: begin
               next_sram_rd   = 1'b1;
               next_sram_addr = f_route.word_addr;
            end
            default: begin
               next_prog_rd   = 1'b1;
               next_prog_addr = f_route.word_addr;
            end
         endcase
      end
   end

   // Control register
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         upper_page_exec_enable <= memory_map_pkg::UPPER_EN_RESET;
         code_page_select       <= memory_map_pkg::PAGE_SEL_RESET;
         pointer_width_select   <= {2{memory_map_pkg::WIDTH_RESET}};
      end else if (i_reg_wr && i_reg_addr == memory_map_pkg::CTRL_OFFSET) begin
         upper_page_exec_enable <= i_reg_wdata[memory_map_pkg::UPPER_EN_BIT];
         code_page_select       <= i_reg_wdata[memory_map_pkg::PAGE_SEL_LSB +: 2];
         pointer_width_select   <= {i_reg_wdata[memory_map_pkg::WIDTH1_BIT],
                                    i_reg_wdata[memory_map_pkg::WIDTH0_BIT]};
      end
   end

   // Register read, answered in the following cycle
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_reg_rd) begin
         if (i_reg_addr == memory_map_pkg::CTRL_OFFSET) begin
            o_reg_rdata <= {11'h000, pointer_width_select, code_page_select,
                            upper_page_exec_enable};
         end else if (i_reg_addr == memory_map_pkg::STATUS_OFFSET) begin
            o_reg_rdata <= {14'h0000, exec_seg};
         end else begin
            o_reg_rdata <= 16'h0000;
         end
      end
   end

   // Segment currently supplying instructions
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         exec_seg <= memory_map_pkg::EXEC_SEG_RESET;
      end else if (i_fetch_req) begin
         exec_seg <= f_route.seg;
      end
   end

   // Memory request stage
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_prog_rd    <= 1'b0;
         o_rom_rd     <= 1'b0;
         o_sram_rd    <= 1'b0;
         o_sram_we_lo <= 1'b0;
         o_sram_we_hi <= 1'b0;
         o_prog_addr  <= 16'h0000;
         o_rom_addr   <= 13'h0000;
         o_sram_addr  <= 14'h0000;
         o_sram_wdata <= 16'h0000;
      end else begin
         o_prog_rd    <= next_prog_rd;
         o_rom_rd     <= next_rom_rd;
         o_sram_rd    <= next_sram_rd;
         o_sram_we_lo <= next_we_lo;
         o_sram_we_hi <= next_we_hi;
         o_prog_addr  <= next_prog_addr;
         o_rom_addr   <= next_rom_addr[memory_map_pkg::ROM_AW-1:0];
         o_sram_addr  <= next_sram_addr[memory_map_pkg::SRAM_AW-1:0];
         // A byte store drives its byte on both lanes; the enables pick one
         o_sram_wdata <= d_route.byte_mode ? {2{i_data_wdata[7:0]}} : i_data_wdata;
      end
   end

   // Reads in flight
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         f_pend <= '0;
         d_pend <= '0;
      end else begin
         f_pend <= {i_fetch_req, f_route.seg, 1'b0, 1'b0};
         d_pend <= {i_data_rd, d_route.seg, d_route.byte_mode, d_route.lane};
      end
   end

   // Word returned for the pending data read, before byte selection
   assign d_word = pick_word(d_pend.seg, i_prog_rdata, i_rom_rdata, i_sram_rdata);

   // Steering of returned words
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_fetch_valid <= 1'b0;
         o_fetch_word  <= 16'h0000;
         o_data_valid  <= 1'b0;
         o_data_rdata  <= 16'h0000;
      end else begin
         o_fetch_valid <= f_pend.valid;
         o_data_valid  <= d_pend.valid;
         if (f_pend.valid) begin
            o_fetch_word <= pick_word(f_pend.seg, i_prog_rdata, i_rom_rdata,
                                      i_sram_rdata);
         end
         if (d_pend.valid) begin
            if (d_pend.byte_mode) begin
               o_data_rdata <= {8'h00, d_pend.lane ? d_word[15:8] : d_word[7:0]};
            end else begin
               o_data_rdata <= d_word;
            end
         end
      end
   end

   logic [15:0] sram_fetch_off;
   assign sram_fetch_off = i_fetch_addr - memory_map_pkg::SRAM_FETCH_BASE;

   AST_USER_LOW: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_fetch_req && !i_fetch_addr[15] |=> o_prog_rd && o_prog_addr == $past(i_fetch_addr))
      else $error("Lower user fetch not sent to program memory");

   AST_UPPER_PAGES: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_fetch_req && i_fetch_addr[15] && upper_page_exec_enable
      |=> o_prog_rd && !o_rom_rd && o_prog_addr[15])
      else $error("Upper page fetch misrouted");

   AST_NO_ROM_WITH_UPPER: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_fetch_req && upper_page_exec_enable && !i_data_rd |=> !o_rom_rd && !o_sram_rd)
      else $error("ROM or SRAM fetched with upper pages enabled");

   AST_SRAM_FETCH: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_fetch_req && !upper_page_exec_enable && i_fetch_addr >= 16'ha000
      |=> o_sram_rd && o_sram_addr == $past(sram_fetch_off[13:0]))
      else $error("Data memory fetch offset wrong");

   AST_ROM_FETCH: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_fetch_req && !upper_page_exec_enable && i_fetch_addr[15:13] == 3'h4
      |=> o_rom_rd && o_rom_addr == $past(i_fetch_addr[12:0]))
      else $error("Utility ROM fetch offset wrong");

   AST_WORD_STORE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_data_wr && wide && d_route.seg == memory_map_pkg::SEG_SRAM
      |=> o_sram_we_lo && o_sram_we_hi && o_sram_wdata == $past(i_data_wdata))
      else $error("Word store to data memory not issued");

   AST_PAGE_WORD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_data_rd && !i_fetch_req && exec_seg == memory_map_pkg::SEG_ROM && wide
      && i_data_addr[15] |=> o_prog_rd && o_prog_addr[15] == $past(code_page_select[1]))
      else $error("Word mode page pair wrong");

   AST_PAGE_BYTE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_data_rd && !i_fetch_req && exec_seg == memory_map_pkg::SEG_ROM && !wide
      && i_data_addr[15] |=> o_prog_addr[15:14] == $past(code_page_select))
      else $error("Byte mode page wrong");

   AST_RAMEXEC_MAP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_data_rd && !i_fetch_req && exec_seg == memory_map_pkg::SEG_SRAM
      |=> (o_prog_rd != $past(i_data_addr[15])) && (o_rom_rd == $past(i_data_addr[15])))
      else $error("Map while executing from data memory wrong");

   AST_USER_ROM_DATA: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_data_rd && !i_fetch_req && exec_seg == memory_map_pkg::SEG_USER && i_data_addr[15]
      |=> o_rom_rd)
      else $error("ROM not read as data from lower pages");

   AST_NO_SELF_DATA: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      data_req |-> d_route.seg != cur_exec)
      else $error("Executing segment accessed as data");

   AST_BYTE_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_data_wr && !wide && d_route.seg == memory_map_pkg::SEG_SRAM
      |=> (o_sram_we_lo ^ o_sram_we_hi) && o_sram_we_hi == $past(i_data_addr[0]))
      else $error("Byte write enabled wrong bank");

   AST_FETCH_WORD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_fetch_req |-> ##2 o_fetch_valid)
      else $error("Fetch word not delivered two cycles later");

   AST_BYTE_READ: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_data_rd && !wide |-> ##2 o_data_valid && o_data_rdata[15:8] == 8'h00)
      else $error("Byte read not zero extended");

endmodule : unified_memory_map_decoder

// file: verification/memory_model.sv
// Behavioural program pages, utility ROM and byte-banked data SRAM
`timescale 1ns/100ps
module memory_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_prog_rd,
   input  wire logic [15:0] i_prog_addr,
   output logic      [15:0] o_prog_rdata,
   input  wire logic        i_rom_rd,
   input  wire logic [12:0] i_rom_addr,
   output logic      [15:0] o_rom_rdata,
   input  wire logic        i_sram_rd,
   input  wire logic [13:0] i_sram_addr,
   input  wire logic        i_sram_we_lo,
   input  wire logic        i_sram_we_hi,
   input  wire logic [15:0] i_sram_wdata,
   output logic      [15:0] o_sram_rdata
);
   logic [15:0] sram [16384];
   logic [15:0] now_w [3];
   logic [15:0] outw [3];
   logic [15:0] last [3] = '{default: 16'h0};
   logic [2:0]  hold = 3'h0;
   logic [2:0]  rd;
   initial begin
      for (int i = 0; i < 16384; i++) begin
         sram[i] = {2'h2, 14'(i)} ^ 16'h0f0f;
      end
   end
   // Two byte banks on one word address, each with its own enable
   always @(posedge i_sys_clk) begin
      if (i_sram_we_lo) sram[i_sram_addr][7:0] <= i_sram_wdata[7:0];
      if (i_sram_we_hi) sram[i_sram_addr][15:8] <= i_sram_wdata[15:8];
   end
   assign rd = {i_sram_rd, i_rom_rd, i_prog_rd};
   assign now_w[0] = i_prog_addr ^ 16'h3c00;
   assign now_w[1] = {3'h5, i_rom_addr};
   assign now_w[2] = sram[i_sram_addr];
   // Data holds one cycle after a read, then the bus shows a changing pattern
   for (genvar k = 0; k < 3; k++) begin : g_bus
      assign outw[k] = rd[k] ? now_w[k] : (hold[k] ? last[k] : ~last[k]);
   end
   always @(posedge i_sys_clk) begin
      hold <= rd;
      last <= outw;
   end
   assign o_prog_rdata = outw[0];
   assign o_rom_rdata = outw[1];
   assign o_sram_rdata = outw[2];
endmodule : memory_model

// file: verification/test_unified_memory_map_decoder.sv
// Random and directed bench for the memory map decoder
`timescale 1ns/100ps
module test_unified_memory_map_decoder;
   logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic i_fetch_req = 1'b0, i_data_rd = 1'b0, i_data_wr = 1'b0, i_data_ptr = 1'b0;
   logic [3:0]  i_reg_addr = 4'h0;
   logic [15:0] i_reg_wdata = 16'h0, i_fetch_addr = 16'h0, i_data_addr = 16'h0;
   logic [15:0] i_data_wdata = 16'h0, o_reg_rdata, o_fetch_word, o_data_rdata;
   logic [15:0] o_prog_addr, i_prog_rdata, i_rom_rdata, o_sram_wdata, i_sram_rdata;
   logic        o_fetch_valid, o_data_valid, o_prog_rd, o_rom_rd, o_sram_rd;
   logic        o_sram_we_lo, o_sram_we_hi;
   logic [12:0] o_rom_addr;
   logic [13:0] o_sram_addr;
   int          mismatches = 0, check_count = 0;
   logic [31:0] seed = 32'hed50;
   logic        upper_en = 1'b0;
   logic [1:0]  page_sel = 2'h0, width_sel = 2'h3;
   logic [15:0] shadow [int];
   logic [15:0] faddr [7] = '{16'h0000, 16'h7fff, 16'h8000, 16'h9fff, 16'ha000, 16'ha123,
                              16'hffff};
   memory_map_pkg::seg_t exec = memory_map_pkg::SEG_ROM;

   unified_memory_map_decoder unified_memory_map_decoder_i (.i_sys_clk, .i_rstn, .i_reg_addr,
      .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_fetch_req, .i_fetch_addr,
      .o_fetch_valid, .o_fetch_word, .i_data_rd, .i_data_wr, .i_data_ptr, .i_data_addr,
      .i_data_wdata, .o_data_valid, .o_data_rdata, .o_prog_rd, .o_prog_addr, .i_prog_rdata,
      .o_rom_rd, .o_rom_addr, .i_rom_rdata, .o_sram_rd, .o_sram_addr, .o_sram_we_lo,
      .o_sram_we_hi, .o_sram_wdata, .i_sram_rdata);
   memory_model memory_model_i (.i_sys_clk, .i_prog_rd(o_prog_rd), .i_prog_addr(o_prog_addr),
      .o_prog_rdata(i_prog_rdata), .i_rom_rd(o_rom_rd), .i_rom_addr(o_rom_addr),
      .o_rom_rdata(i_rom_rdata), .i_sram_rd(o_sram_rd), .i_sram_addr(o_sram_addr),
      .i_sram_we_lo(o_sram_we_lo), .i_sram_we_hi(o_sram_we_hi),
      .i_sram_wdata(o_sram_wdata), .o_sram_rdata(i_sram_rdata));

   always #5 i_sys_clk = ~i_sys_clk;

   function automatic logic [15:0] sram_word(input logic [13:0] a);
      return shadow.exists(a) ? shadow[a] : ({2'h2, a} ^ 16'h0f0f);
   endfunction : sram_word
   // Data access lands in SRAM only in the lower half and never while running from it
   function automatic logic to_sram(input logic [15:0] a);
      return !a[15] && exec != memory_map_pkg::SEG_SRAM;
   endfunction : to_sram
   function automatic logic [15:0] exp_data(input logic [15:0] a, input logic bm);
      logic [15:0] w, wa;
      wa = bm ? {2'h0, a[14:1]} : {1'b0, a[14:0]};
      if (exec != memory_map_pkg::SEG_USER && (exec == memory_map_pkg::SEG_ROM) == a[15])
         w = (bm ? {page_sel, a[14:1]} : {page_sel[1], a[14:0]}) ^ 16'h3c00;
      else if (a[15]) w = {3'h5, wa[12:0]};
      else w = sram_word(wa[13:0]);
      return bm ? {8'h0, a[0] ? w[15:8] : w[7:0]} : w;
   endfunction : exp_data
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic wait_valid(ref logic flag);
      for (int n = 0; flag !== 1'b1; n++) begin
         if (n == 8) begin
            mismatches++;
            print_verdict();
         end
         @(posedge i_sys_clk);
         #1;
      end
   endtask : wait_valid
   task automatic reg_access(input logic wr, input logic [3:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      i_reg_wr <= wr;
      i_reg_rd <= !wr;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b0;
      #1;
      if (!wr) check("register read", d, o_reg_rdata);
   endtask : reg_access
   task automatic set_ctrl();
      reg_access(1'b1, 4'h0, {11'h0, width_sel, page_sel, upper_en});
   endtask : set_ctrl
   task automatic do_fetch(input logic [15:0] a);
      logic [15:0] exp;
      exp = (a < 16'h8000 || upper_en) ? a ^ 16'h3c00 : (a >= 16'ha000) ?
            sram_word(14'(a - 16'ha000)) : {3'h5, a[12:0]};
      exec = (a < 16'h8000 || upper_en) ? memory_map_pkg::SEG_USER :
             (a >= 16'ha000) ? memory_map_pkg::SEG_SRAM : memory_map_pkg::SEG_ROM;
      @(posedge i_sys_clk);
      i_fetch_req <= 1'b1;
      i_fetch_addr <= a;
      @(posedge i_sys_clk);
      i_fetch_req <= 1'b0;
      wait_valid(o_fetch_valid);
      check("fetch word", exp, o_fetch_word);
      reg_access(1'b0, 4'h1, {14'h0, 2'(exec)});
   endtask : do_fetch
   task automatic data_op(input logic wr, input logic p, input logic [15:0] a,
                          input logic [15:0] d);
      logic bm, s;
      logic [15:0] exp, other;
      bm = !width_sel[p];
      s = to_sram(a);
      exp = exp_data(a, bm);
      other = exp_data(a ^ 16'h1, 1'b1);
      @(posedge i_sys_clk);
      {i_data_wr, i_data_rd, i_data_ptr, i_data_addr, i_data_wdata} <= {wr, !wr, p, a, d};
      @(posedge i_sys_clk);
      {i_data_wr, i_data_rd} <= 2'h0;
      #1;
      check("exec segment strobe", 16'h0,
            16'(({o_sram_rd, o_rom_rd, o_prog_rd} >> exec) & 3'h1));
      if (wr) begin
         check("lane enables", {14'h0, s && (!bm || a[0]), s && (!bm || !a[0])},
               {14'h0, o_sram_we_hi, o_sram_we_lo});
         if (s && bm) shadow[a[14:1]] = a[0] ? {d[7:0], other[7:0]} : {other[7:0], d[7:0]};
         else if (s) shadow[a[13:0]] = d;
      end else begin
         wait_valid(o_data_valid);
         check("load", exp, o_data_rdata);
      end
   endtask : data_op

   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      reg_access(1'b0, 4'h0, 16'h0018);
      reg_access(1'b0, 4'h1, 16'h0001);
      reg_access(1'b1, 4'h7, 16'hffff);
      reg_access(1'b0, 4'h7, 16'h0000);
      for (int u = 0; u < 2; u++) begin
         upper_en = u[0];
         set_ctrl();
         foreach (faddr[i]) do_fetch(faddr[i]);
      end
      upper_en = 1'b0;
      width_sel = 2'h2;
      set_ctrl();
      do_fetch(16'h0100);
      data_op(1'b1, 1'b0, 16'h0003, 16'h00ab);
      data_op(1'b0, 1'b0, 16'h0003, 16'h0);
      data_op(1'b0, 1'b0, 16'h0002, 16'h0);
      data_op(1'b0, 1'b1, 16'h0001, 16'h0);
      data_op(1'b0, 1'b0, 16'h7fff, 16'h0);
      for (int i = 0; i < 400; i++) begin
         seed = lfsr_next(seed);
         if (i % 16 == 0) begin
            {upper_en, page_sel, width_sel} = {seed[8] & seed[9], seed[11:10], seed[13:12]};
            set_ctrl();
            do_fetch(seed[31:16]);
         end else data_op(seed[0], seed[1], seed[31:16], seed[15:0]);
      end
      print_verdict();
   end
endmodule : test_unified_memory_map_decoder
